// File: rtl/alignment_and_opcode_check.sv
// Purpose: alignment and opcode exception unit with status registers
// Assumes: one request per cycle from decode and load/store pipe
// Notes: verdicts appear one cycle after the request, memory go is gated
`timescale 1ns/1ps
`default_nettype none
module alignment_and_opcode_check
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic req_valid_i,
	input wire logic [31:0] insn_i,
	input wire align_opc_pkg::mem_op_t mem_op_i,
	input wire align_opc_pkg::op_size_t size_i,
	input wire logic [31:0] effective_address_i,
	input wire logic cacheable_i,
	input wire logic write_through_i,
	input wire logic data_translation_enable_i,
	input wire logic [31:0] fetch_pc_i,
	output logic [31:0] fetch_addr_o,
	output logic done_o,
	output logic align_exc_o,
	output logic [15:0] align_vector_o,
	output logic program_exc_o,
	output align_opc_pkg::insn_class_t insn_class_o,
	output logic invalid_form_o,
	output logic unimpl_o,
	output logic slow_form_o,
	output logic split_o,
	output logic mem_go_o,
	output logic [31:0] access_addr_o,
	output logic irq_o
);
	import align_opc_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [31:0] fault_addr;
		logic [31:0] fault_insn;
		logic [31:0] rdata;
		logic done;
		logic align_exc;
		logic prog_exc;
		insn_class_t cls;
		logic invalid;
		logic unimpl;
		logic slow;
		logic split;
		logic mem_go;
		logic [31:0] access_addr;
		logic [31:0] fetch_addr;
	} unit_state_t;

	unit_state_t st_r;
	unit_state_t st_nxt;

	logic align_exc_c;
	logic split_c;
	logic [31:0] access_addr_c;
	insn_class_t cls_c;
	logic unimpl_c;
	logic invalid_c;
	logic slow_c;

	operand_align_check u_align
	(
		.op_i(mem_op_i),
		.size_i(size_i),
		.effective_address_i(effective_address_i),
		.cacheable_i(cacheable_i),
		.write_through_i(write_through_i),
		.data_translation_enable_i(data_translation_enable_i),
		.align_exc_o(align_exc_c),
		.split_o(split_c),
		.access_addr_o(access_addr_c)
	);

	opcode_classify u_classify
	(
		.insn_i(insn_i),
		.class_o(cls_c),
		.unimpl_o(unimpl_c),
		.invalid_o(invalid_c),
		.slow_form_o(slow_c)
	);

	logic is_mem;
	logic reserved_unimpl;
	logic prog_c;
	logic align_c;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] w1c;

	assign is_mem = (mem_op_i != MOP_NONE);
	// primary 4 is the implemented allocated group, every other reserved code is not
	assign reserved_unimpl = (cls_c == CL_RESERVED) && (insn_i[31:26] != 6'h04);
	assign align_c = req_valid_i && is_mem && align_exc_c;
	assign prog_c = req_valid_i && ((cls_c == CL_ILLEGAL) || reserved_unimpl ||
		(unimpl_c && st_r.ctrl[CTRL_UNIMPL_TRAP]) ||
		(invalid_c && st_r.ctrl[CTRL_INVALID_TRAP]));

	always_comb
	begin
		events = '0;
		events[EV_ALIGN] = align_c;
		events[EV_ILLEGAL] = req_valid_i && ((cls_c == CL_ILLEGAL) || reserved_unimpl);
		events[EV_UNIMPL] = req_valid_i && unimpl_c;
		events[EV_INVALID] = req_valid_i && invalid_c;
		events[EV_SPLIT] = req_valid_i && split_c;
	end

	assign w1c = (wr_i && addr_i == OFF_STATUS) ? wdata_i[EV_W-1:0] : '0;

	always_comb
	begin
		st_nxt = st_r;
		// register writes
		if (wr_i && addr_i == OFF_CTRL)
			st_nxt.ctrl = wdata_i[CTRL_W-1:0];
		else if (wr_i && addr_i == OFF_MASK)
			st_nxt.mask = wdata_i[EV_W-1:0];
		// a new event wins over a clear in the same cycle
		st_nxt.status = (st_r.status & ~w1c) | events;
		// register reads, answered in the next cycle only
		st_nxt.rdata = 32'h0000_0000;
		if (rd_i)
		begin
			if (addr_i == OFF_CTRL)
				st_nxt.rdata = {{(32-CTRL_W){1'b0}}, st_r.ctrl};
			else if (addr_i == OFF_STATUS)
				st_nxt.rdata = {{(32-EV_W){1'b0}}, st_r.status};
			else if (addr_i == OFF_MASK)
				st_nxt.rdata = {{(32-EV_W){1'b0}}, st_r.mask};
			else if (addr_i == OFF_FAULT_ADDR)
				st_nxt.rdata = st_r.fault_addr;
			else if (addr_i == OFF_FAULT_INSN)
				st_nxt.rdata = st_r.fault_insn;
			else
				st_nxt.rdata = 32'h0000_0000;
		end
		// per-request verdicts
		st_nxt.done = req_valid_i;
		st_nxt.align_exc = align_c;
		st_nxt.prog_exc = prog_c;
		st_nxt.cls = cls_c;
		st_nxt.invalid = req_valid_i && invalid_c;
		st_nxt.unimpl = req_valid_i && unimpl_c;
		st_nxt.slow = req_valid_i && slow_c;
		st_nxt.split = req_valid_i && is_mem && split_c;
		// the access is released only once both checks are clean
		st_nxt.mem_go = req_valid_i && is_mem && !align_exc_c && !prog_c;
		st_nxt.access_addr = access_addr_c;
		st_nxt.fetch_addr = {fetch_pc_i[31:FETCH_LOW_BITS], {FETCH_LOW_BITS{1'b0}}};
		if (align_c || prog_c)
		begin
			st_nxt.fault_addr = effective_address_i;
			st_nxt.fault_insn = insn_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RST;
			st_r.mask <= MASK_RST;
			st_r.cls <= CL_DEFINED;
		end
		else
			st_r <= st_nxt;
	end

	assign rdata_o = st_r.rdata;
	assign fetch_addr_o = st_r.fetch_addr;
	assign done_o = st_r.done;
	assign align_exc_o = st_r.align_exc;
	assign align_vector_o = st_r.align_exc ? ALIGN_VECTOR : 16'h0000;
	assign program_exc_o = st_r.prog_exc;
	assign insn_class_o = st_r.cls;
	assign invalid_form_o = st_r.invalid;
	assign unimpl_o = st_r.unimpl;
	assign slow_form_o = st_r.slow;
	assign split_o = st_r.split;
	assign mem_go_o = st_r.mem_go;
	assign access_addr_o = st_r.access_addr;
	assign irq_o = |(st_r.status & st_r.mask);

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	a_fault_blocks_access: assert property (
		done_o && (align_exc_o || program_exc_o) |-> !mem_go_o)
		else $error("memory access released for a faulting request");

	a_reserve_word_align: assert property (
		req_valid_i && (mem_op_i inside {MOP_DCREAD, MOP_LWARX, MOP_STWCX}) && effective_address_i[1:0] != 2'h0
		|=> align_exc_o && !mem_go_o)
		else $error("misaligned reservation access not faulted");

	a_zero_block_attr: assert property (
		req_valid_i && mem_op_i == MOP_DCBZ && !data_translation_enable_i && (!cacheable_i || write_through_i)
		|=> align_exc_o && align_vector_o == 16'h0600)
		else $error("zero-block to uncached region not faulted at 0x0600");

	a_plain_no_fault: assert property (
		req_valid_i && (mem_op_i == MOP_LOAD || mem_op_i == MOP_STORE) |=> !align_exc_o)
		else $error("ordinary load or store raised alignment fault");

	a_word_split: assert property (
		req_valid_i && mem_op_i == MOP_LOAD && size_i == SZ_WORD
		|=> split_o == ($past(effective_address_i[1:0]) != 2'h0))
		else $error("word alignment verdict wrong");

	a_cache_low_bits: assert property (
		req_valid_i && mem_op_i == MOP_CACHE
		|=> access_addr_o[3:0] == 4'h0 && access_addr_o[31:4] == $past(effective_address_i[31:4]) && !align_exc_o)
		else $error("cache op address low bits not dropped");

	a_zero_word_trap: assert property (
		req_valid_i && insn_i == 32'h0000_0000 |=> insn_class_o == CL_ILLEGAL && program_exc_o)
		else $error("all-zero word not trapped as illegal");

	a_zero_primary_rsvd: assert property (
		req_valid_i && insn_i[31:26] == 6'h00 && insn_i[25:0] != 26'h0
		|=> insn_class_o == CL_RESERVED && program_exc_o)
		else $error("zero primary opcode not reserved and trapped");

	a_float_unimpl: assert property (
		req_valid_i && insn_i[31:26] == 6'h30 |=> unimpl_o)
		else $error("floating-point load not marked unimplemented");

	a_fetch_word: assert property (
		##1 fetch_addr_o[1:0] == 2'h0 && fetch_addr_o[31:2] == $past(fetch_pc_i[31:2]))
		else $error("fetch address not word aligned");

	a_irq_follows: assert property (
		$rose(st_r.status[EV_ALIGN]) && st_r.mask[EV_ALIGN] |-> irq_o)
		else $error("unmasked alignment event without interrupt");

	a_done_follows: assert property (
		1'b1 |=> done_o == $past(req_valid_i))
		else $error("done pulse does not follow the request");

	a_vector_idle: assert property (
		!align_exc_o |-> align_vector_o == 16'h0000)
		else $error("alignment vector shown without a fault");

	a_vector_on_fault: assert property (
		align_exc_o |-> align_vector_o == 16'h0600)
		else $error("alignment fault without its vector");

	a_none_no_access: assert property (
		req_valid_i && mem_op_i == MOP_NONE |=> !align_exc_o && !mem_go_o && !split_o)
		else $error("request without memory operation released or faulted");

	a_half_split: assert property (
		req_valid_i && mem_op_i == MOP_STORE && size_i == SZ_HALF
		|=> split_o == $past(effective_address_i[0]))
		else $error("halfword alignment verdict wrong");

	a_double_split: assert property (
		req_valid_i && mem_op_i == MOP_LOAD && size_i == SZ_DOUBLE
		|=> split_o == ($past(effective_address_i[2:0]) != 3'h0))
		else $error("doubleword alignment verdict wrong");

	a_byte_no_split: assert property (
		req_valid_i && (mem_op_i == MOP_LOAD || mem_op_i == MOP_STORE) && size_i == SZ_BYTE |=> !split_o)
		else $error("byte access marked misaligned");

	a_reserve_aligned: assert property (
		req_valid_i && (mem_op_i inside {MOP_DCREAD, MOP_LWARX, MOP_STWCX}) && effective_address_i[1:0] == 2'h0
		|=> !align_exc_o)
		else $error("word-aligned reservation access faulted");

	a_zero_block_mapped: assert property (
		req_valid_i && mem_op_i == MOP_DCBZ && (data_translation_enable_i || (cacheable_i && !write_through_i))
		|=> !align_exc_o)
		else $error("zero-block faulted although translated or cached copy-back");

	a_zero_block_addr: assert property (
		req_valid_i && mem_op_i == MOP_DCBZ
		|=> access_addr_o == {$past(effective_address_i[31:4]), 4'h0})
		else $error("zero-block address low bits not dropped");

	a_plain_addr_kept: assert property (
		req_valid_i && (mem_op_i == MOP_LOAD || mem_op_i == MOP_STORE)
		|=> access_addr_o == $past(effective_address_i))
		else $error("ordinary access address altered");

	a_go_needs_request: assert property (
		mem_go_o |-> done_o && !align_exc_o && !program_exc_o)
		else $error("memory access released without a clean request");

	a_illegal_traps: assert property (
		done_o && insn_class_o == CL_ILLEGAL |-> program_exc_o)
		else $error("illegal instruction without program exception");

	a_allocated_kept: assert property (
		req_valid_i && insn_i[31:26] == 6'h04 |=> insn_class_o == CL_RESERVED && !program_exc_o)
		else $error("implemented reserved group misclassified or trapped");

	a_unused_primary: assert property (
		req_valid_i && insn_i[31:26] == 6'h01 |=> insn_class_o == CL_ILLEGAL && program_exc_o)
		else $error("unused primary opcode not trapped as illegal");

	a_unimpl_trap: assert property (
		done_o && unimpl_o && $past(st_r.ctrl[CTRL_UNIMPL_TRAP]) |-> program_exc_o)
		else $error("unimplemented instruction not trapped while enabled");

	a_invalid_trap: assert property (
		done_o && invalid_form_o && $past(st_r.ctrl[CTRL_INVALID_TRAP]) |-> program_exc_o)
		else $error("invalid form not trapped while enabled");

	a_invalid_quiet: assert property (
		done_o && invalid_form_o && !unimpl_o && !$past(st_r.ctrl[CTRL_INVALID_TRAP]) |-> !program_exc_o)
		else $error("invalid form trapped while disabled");

	a_flags_defined: assert property (
		(unimpl_o || invalid_form_o) |-> insn_class_o == CL_DEFINED)
		else $error("unimplemented or invalid flag on a non-defined word");

	a_update_base_zero: assert property (
		req_valid_i && insn_i[31:26] == 6'h21 && insn_i[20:16] == 5'h00 |=> invalid_form_o)
		else $error("load with update and base zero not invalid");

	a_compare_bit: assert property (
		req_valid_i && insn_i[31:26] == 6'h0b && insn_i[21] |=> invalid_form_o)
		else $error("compare with reserved bit set not invalid");

	a_tlb_unimpl: assert property (
		req_valid_i && insn_i[31:26] == 6'h1f && insn_i[10:1] == 10'h132 |=> unimpl_o)
		else $error("translation-buffer invalidate not marked unimplemented");

	a_nop_fast: assert property (
		req_valid_i && insn_i == 32'h6000_0000 |=> !slow_form_o)
		else $error("preferred no-operation marked slow");

	a_status_sets: assert property (
		done_o && align_exc_o |-> st_r.status[EV_ALIGN])
		else $error("alignment fault left no status bit");

	a_rdata_idle: assert property (
		!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data shown without a read");
endmodule
`default_nettype wire

// File: pkg/align_opc_pkg.sv
// Purpose: shared constants and types for the alignment and opcode checker
// Assumes: 32-bit core, big-endian bit numbering on the instruction word
// Notes: register offsets are byte addresses on the plain register port
// Function
// - operand aligned when low bits suit size
// - instructions fetched as aligned four-byte words
// - endian attribute never changes alignment handling
// - ordinary misaligned loads/stores complete, no exception
// - dcread/reservation ops need word-aligned address
// - cache ops drop four low address bits
// - zero-block to uncached/write-through, translation off, faults
// - classify by primary and extended opcode
// - unimplemented instructions may trap for emulation
// - invalid forms undefined or trap
// - detect invalid forms of four groups
// - no floating point, external control, tlb invalidate
// - only preferred forms run fast
// - all-zero word illegal, zero primary reserved
// - illegal or unimplemented reserved raises program exception
package align_opc_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_FAULT_ADDR = 8'h0c;
	localparam logic [7:0] OFF_FAULT_INSN = 8'h10;
	localparam int EV_W = 5;
	localparam int EV_ALIGN = 0;
	localparam int EV_ILLEGAL = 1;
	localparam int EV_UNIMPL = 2;
	localparam int EV_INVALID = 3;
	localparam int EV_SPLIT = 4;
	localparam int CTRL_W = 2;
	localparam int CTRL_INVALID_TRAP = 0;
	localparam int CTRL_UNIMPL_TRAP = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;
	localparam logic [EV_W-1:0] MASK_RST = 5'h00;
	localparam logic [15:0] ALIGN_VECTOR = 16'h0600;
	localparam int CACHE_LOW_BITS = 4;
	localparam int FETCH_LOW_BITS = 2;
	typedef enum logic [2:0] {
		MOP_NONE = 3'h0,
		MOP_LOAD = 3'h1,
		MOP_STORE = 3'h2,
		MOP_DCREAD = 3'h3,
		MOP_LWARX = 3'h4,
		MOP_STWCX = 3'h5,
		MOP_DCBZ = 3'h6,
		MOP_CACHE = 3'h7
	} mem_op_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2,
		SZ_DOUBLE = 2'h3
	} op_size_t;
	typedef enum logic [1:0] {
		CL_DEFINED = 2'h0,
		CL_RESERVED = 2'h1,
		CL_ILLEGAL = 2'h2
	} insn_class_t;
endpackage

// File: rtl/operand_align_check.sv
// Purpose: combinational alignment verdict for one data access
// Assumes: effective address already computed by the load/store pipe
// Notes: no endian input on purpose, both byte orders see the same checks
`timescale 1ns/1ps
`default_nettype none
module operand_align_check
(
	input wire align_opc_pkg::mem_op_t op_i,
	input wire align_opc_pkg::op_size_t size_i,
	input wire logic [31:0] effective_address_i,
	input wire logic cacheable_i,
	input wire logic write_through_i,
	input wire logic data_translation_enable_i,
	output logic align_exc_o,
	output logic split_o,
	output logic [31:0] access_addr_o
);
	import align_opc_pkg::*;

	function automatic logic natural_ok(input op_size_t sz, input logic [3:0] low);
		case (sz)
			SZ_BYTE: natural_ok = 1'b1;
			SZ_HALF: natural_ok = (low[0] == 1'b0);
			SZ_WORD: natural_ok = (low[1:0] == 2'h0);
			default: natural_ok = (low[2:0] == 3'h0);
		endcase
	endfunction

	logic word_ok;
	logic reserve_op;
	logic dcbz_fault;
	assign word_ok = (effective_address_i[1:0] == 2'h0);
	assign reserve_op = (op_i == MOP_DCREAD) || (op_i == MOP_LWARX) || (op_i == MOP_STWCX);
	assign dcbz_fault = (op_i == MOP_DCBZ) && !data_translation_enable_i && (!cacheable_i || write_through_i);
	assign align_exc_o = (reserve_op && !word_ok) || dcbz_fault;
	assign split_o = ((op_i == MOP_LOAD) || (op_i == MOP_STORE)) &&
		!natural_ok(size_i, effective_address_i[3:0]);
	assign access_addr_o = ((op_i == MOP_CACHE) || (op_i == MOP_DCBZ)) ?
		{effective_address_i[31:CACHE_LOW_BITS], {CACHE_LOW_BITS{1'b0}}} : effective_address_i;
endmodule
`default_nettype wire

// File: rtl/opcode_classify.sv
// Purpose: sort an instruction word into defined, reserved or illegal
// Assumes: word already in big-endian order, bit 31 is architectural bit 0
// Notes: primary 31 is taken as defined for every extended code, the listed unimplemented codes included
`timescale 1ns/1ps
`default_nettype none
module opcode_classify
(
	input wire logic [31:0] insn_i,
	output align_opc_pkg::insn_class_t class_o,
	output logic unimpl_o,
	output logic invalid_o,
	output logic slow_form_o
);
	import align_opc_pkg::*;
	localparam logic [63:0] PO_DEFINED = 64'h88ff_ffff_bfbf_fd88;
	localparam logic [63:0] PO_FLOAT = 64'h88ff_0000_0000_0000;

	function automatic logic xo19_defined(input logic [9:0] xo);
		case (xo)
			10'h000, 10'h010, 10'h021, 10'h032, 10'h033, 10'h081, 10'h096,
			10'h0c1, 10'h0e1, 10'h101, 10'h121, 10'h1a1, 10'h1c1, 10'h210: xo19_defined = 1'b1;
			default: xo19_defined = 1'b0;
		endcase
	endfunction

	function automatic logic xo31_unimpl(input logic [9:0] xo);
		case (xo)
			10'h132, 10'h136, 10'h1b6, 10'h217, 10'h237, 10'h257, 10'h277,
			10'h297, 10'h2b7, 10'h2d7, 10'h2f7, 10'h3d7: xo31_unimpl = 1'b1;
			default: xo31_unimpl = 1'b0;
		endcase
	endfunction

	logic [5:0] po;
	logic [4:0] rt;
	logic [4:0] ra;
	logic [4:0] bo;
	logic [9:0] xo;
	assign po = insn_i[31:26];
	assign rt = insn_i[25:21];
	assign ra = insn_i[20:16];
	assign bo = insn_i[25:21];
	assign xo = insn_i[10:1];

	always_comb
	begin
		if (insn_i == 32'h0000_0000)
			class_o = CL_ILLEGAL;
		else if (po == 6'h00 || po == 6'h04)
			class_o = CL_RESERVED;
		else if (!PO_DEFINED[po])
			class_o = CL_ILLEGAL;
		else if (po == 6'h13 && !xo19_defined(xo))
			class_o = CL_ILLEGAL;
		else
			class_o = CL_DEFINED;
	end

	assign unimpl_o = (class_o == CL_DEFINED) && (PO_FLOAT[po] || (po == 6'h1f && xo31_unimpl(xo)));

	logic bc_bad;
	logic upd_bad;
	logic multi_bad;
	logic cmp_bad;
	assign bc_bad = (po == 6'h10 || (po == 6'h13 && (xo == 10'h010 || xo == 10'h210))) &&
		((bo[4] && bo[3]) || (!bo[4] && bo[2] && bo[1]) || (bo[4] && bo[2] && (bo[1] || bo[0])));
	assign upd_bad = ((po == 6'h21 || po == 6'h23 || po == 6'h29 || po == 6'h2b) && (ra == 5'h00 || ra == rt)) ||
		((po == 6'h25 || po == 6'h27 || po == 6'h2d) && ra == 5'h00);
	assign multi_bad = (po == 6'h2e && ra >= rt) || (po == 6'h1f && xo == 10'h255 && ra == rt);
	assign cmp_bad = ((po == 6'h0a || po == 6'h0b) && (insn_i[22] || insn_i[21])) ||
		(po == 6'h1f && (xo == 10'h000 || xo == 10'h020) && (insn_i[22] || insn_i[21] || insn_i[0]));
	assign invalid_o = (class_o == CL_DEFINED) && (bc_bad || upd_bad || multi_bad || cmp_bad);

	// base register zero on multiple/string, or a no-op not written as ori 0,0,0
	assign slow_form_o = (((po == 6'h2e || po == 6'h2f) || (po == 6'h1f && (xo == 10'h255 || xo == 10'h2d5))) &&
		ra == 5'h00) || (po == 6'h18 && rt == ra && insn_i[15:0] == 16'h0000 && rt != 5'h00);
endmodule
`default_nettype wire

// File: sim/alignment_and_opcode_check_bench.sv
// Purpose: self-checking bench for the alignment and opcode exception unit
// Assumes: request verdicts and read data appear one cycle after the strobe
// Notes: no random stimulus, every case is a directed call with its expectation
`timescale 1ns/1ps
`default_nettype none
module alignment_and_opcode_check_bench;
	import align_opc_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic req_valid_i = 1'b0;
	logic [31:0] insn_i = 32'h0;
	mem_op_t mem_op_i = MOP_NONE;
	op_size_t size_i = SZ_BYTE;
	logic [31:0] effective_address_i = 32'h0;
	logic cacheable_i = 1'b1;
	logic write_through_i = 1'b0;
	logic data_translation_enable_i = 1'b1;
	logic [31:0] fetch_pc_i = 32'h0;
	logic [31:0] fetch_addr_o, access_addr_o;
	logic done_o, align_exc_o, program_exc_o, invalid_form_o, unimpl_o, slow_form_o, split_o, mem_go_o, irq_o;
	logic [15:0] align_vector_o;
	insn_class_t insn_class_o;
	int bad_count = 0;
	int tests_run = 0;
	logic mis;
	alignment_and_opcode_check dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_valid_i(req_valid_i), .insn_i(insn_i),
		.mem_op_i(mem_op_i), .size_i(size_i), .effective_address_i(effective_address_i), .cacheable_i(cacheable_i),
		.write_through_i(write_through_i), .data_translation_enable_i(data_translation_enable_i),
		.fetch_pc_i(fetch_pc_i), .fetch_addr_o(fetch_addr_o), .done_o(done_o), .align_exc_o(align_exc_o),
		.align_vector_o(align_vector_o), .program_exc_o(program_exc_o), .insn_class_o(insn_class_o),
		.invalid_form_o(invalid_form_o), .unimpl_o(unimpl_o), .slow_form_o(slow_form_o), .split_o(split_o),
		.mem_go_o(mem_go_o), .access_addr_o(access_addr_o), .irq_o(irq_o));
	initial
	begin
		forever #4 mclk_i = ~mclk_i;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_rd(a, d);
		chk(name, exp, d);
	endtask
	// one request, outputs looked at in the cycle where they stand
	task automatic req(input mem_op_t op, input op_size_t sz, input logic [31:0] adr, input logic [31:0] insn,
		input logic c, input logic wt, input logic dte);
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		mem_op_i <= op;
		size_i <= sz;
		effective_address_i <= adr;
		insn_i <= insn;
		cacheable_i <= c;
		write_through_i <= wt;
		data_translation_enable_i <= dte;
		fetch_pc_i <= adr;
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		#1;
		chk("done", 32'h1, {31'h0, done_o});
		chk("fetch_addr", {adr[31:2], 2'h0}, fetch_addr_o);
	endtask
	task automatic mem_chk(input logic exc, input logic [31:0] acc);
		chk("align_exc", {31'h0, exc}, {31'h0, align_exc_o});
		chk("align_vector", exc ? 32'h600 : 32'h0, {16'h0, align_vector_o});
		chk("mem_go", {31'h0, ~exc}, {31'h0, mem_go_o});
		chk("access_addr", acc, access_addr_o);
	endtask
	task automatic opc(input logic [31:0] insn, input insn_class_t cls, input logic prog);
		req(MOP_NONE, SZ_WORD, 32'h100, insn, 1'b1, 1'b0, 1'b1);
		chk("class", {30'h0, cls}, {30'h0, insn_class_o});
		chk("program_exc", {31'h0, prog}, {31'h0, program_exc_o});
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		test_done;
	end
	initial
	begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd_chk("ctrl_rst", OFF_CTRL, 32'h2);
		rd_chk("status_rst", OFF_STATUS, 32'h0);
		rd_chk("mask_rst", OFF_MASK, 32'h0);
		rd_chk("unmapped", 8'h40, 32'h0);
		// ordinary accesses never fault, misalignment only costs cycles
		for (int sz = 0; sz < 4; sz++)
		begin
			for (int lo = 0; lo < 16; lo++)
			begin
				mis = (lo & ((1 << sz) - 1)) != 0;
				req((lo % 2) ? MOP_STORE : MOP_LOAD, op_size_t'(sz), {28'h8765432, 4'(lo)}, 32'h60000000,
					1'b0, 1'b1, 1'b0);
				mem_chk(1'b0, {28'h8765432, 4'(lo)});
				chk("split", {31'h0, mis}, {31'h0, split_o});
			end
		end
		for (int lo = 0; lo < 4; lo++)
		begin
			req(MOP_DCREAD, SZ_WORD, {30'h40, 2'(lo)}, 32'h60000000, 1'b1, 1'b0, 1'b1);
			mem_chk(lo != 0, {30'h40, 2'(lo)});
			req(MOP_STWCX, SZ_WORD, {30'h40, 2'(lo)}, 32'h60000000, 1'b0, 1'b1, 1'b0);
			mem_chk(lo != 0, {30'h40, 2'(lo)});
		end
		reg_wr(OFF_STATUS, 32'h1f);
		req(MOP_LWARX, SZ_WORD, 32'h1002, 32'h7c001028, 1'b1, 1'b0, 1'b1);
		mem_chk(1'b1, 32'h1002);
		rd_chk("fault_addr", OFF_FAULT_ADDR, 32'h1002);
		rd_chk("fault_insn", OFF_FAULT_INSN, 32'h7c001028);
		rd_chk("status_align", OFF_STATUS, 32'h1);
		chk("irq_masked", 32'h0, {31'h0, irq_o});
		reg_wr(OFF_MASK, 32'h1);
		@(posedge mclk_i);
		#1;
		chk("irq_set", 32'h1, {31'h0, irq_o});
		reg_wr(OFF_STATUS, 32'h1);
		@(posedge mclk_i);
		#1;
		chk("irq_clr", 32'h0, {31'h0, irq_o});
		rd_chk("status_clr", OFF_STATUS, 32'h0);
		req(MOP_CACHE, SZ_BYTE, 32'h2347, 32'h60000000, 1'b0, 1'b1, 1'b0);
		mem_chk(1'b0, 32'h2340);
		// zero-block faults only for uncached or write-through with translation off
		req(MOP_DCBZ, SZ_BYTE, 32'h3009, 32'h60000000, 1'b0, 1'b0, 1'b0);
		mem_chk(1'b1, 32'h3000);
		req(MOP_DCBZ, SZ_BYTE, 32'h3009, 32'h60000000, 1'b1, 1'b1, 1'b0);
		mem_chk(1'b1, 32'h3000);
		req(MOP_DCBZ, SZ_BYTE, 32'h3009, 32'h60000000, 1'b1, 1'b0, 1'b0);
		mem_chk(1'b0, 32'h3000);
		req(MOP_DCBZ, SZ_BYTE, 32'h3009, 32'h60000000, 1'b0, 1'b1, 1'b1);
		mem_chk(1'b0, 32'h3000);
		opc(32'h00000000, CL_ILLEGAL, 1'b1);
		opc(32'h00000001, CL_RESERVED, 1'b1);
		opc(32'h7ce72214, CL_DEFINED, 1'b0);
		opc(32'h04000000, CL_ILLEGAL, 1'b1);
		opc(32'h10000050, CL_RESERVED, 1'b0);
		opc(32'hc0000000, CL_DEFINED, 1'b1);
		chk("unimpl_fp", 32'h1, {31'h0, unimpl_o});
		opc(32'h7c000264, CL_DEFINED, 1'b1);
		chk("unimpl_tlb", 32'h1, {31'h0, unimpl_o});
		opc(32'h84600000, CL_DEFINED, 1'b0);
		chk("invalid_upd", 32'h1, {31'h0, invalid_form_o});
		opc(32'hb8650000, CL_DEFINED, 1'b0);
		chk("invalid_lmw", 32'h1, {31'h0, invalid_form_o});
		opc(32'h60630000, CL_DEFINED, 1'b0);
		chk("slow_ori", 32'h1, {31'h0, slow_form_o});
		opc(32'h60000000, CL_DEFINED, 1'b0);
		chk("fast_nop", 32'h0, {31'h0, slow_form_o});
		reg_wr(OFF_CTRL, 32'h1);
		rd_chk("ctrl_wr", OFF_CTRL, 32'h1);
		opc(32'h84600000, CL_DEFINED, 1'b1);
		opc(32'h2c200000, CL_DEFINED, 1'b1);
		chk("invalid_cmp", 32'h1, {31'h0, invalid_form_o});
		opc(32'hc0000000, CL_DEFINED, 1'b0);
		rd_chk("status_ev", OFF_STATUS, 32'hf);
		reg_wr(OFF_STATUS, 32'h1f);
		rd_chk("status_w1c", OFF_STATUS, 32'h0);
		test_done;
	end
endmodule
`default_nettype wire
